// File: logic/alarm_oos_pkg.sv
// Shared constants and carriers for the T1 alarm and out-of-service block.
// Assumes a single 10 MHz clock and a plain strobe register port.
package alarm_oos_pkg;

    // Clock rate and timing figures
    localparam longint CLK_HZ = 64'd10_000_000;
    localparam longint SYNC_FAST_MS = 64'd1000;
    localparam longint SYNC_STD_MS = 64'd10000;
    localparam longint OOS_TIMER_MS = 64'd2500;
    localparam int SYNC_FAST_CYC = int'(SYNC_FAST_MS * CLK_HZ / 64'd1000);
    localparam int SYNC_STD_CYC = int'(SYNC_STD_MS * CLK_HZ / 64'd1000);
    localparam int OOS_CYC = int'(OOS_TIMER_MS * CLK_HZ / 64'd1000);

    // Register offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_IDLE = 4'h1;
    localparam logic [3:0] OFS_STAT = 4'h2;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h3;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h4;

    // Control field positions
    localparam int CTRL_SYNC_STD = 0;
    localparam int CTRL_FWD_MAIN = 1;
    localparam int CTRL_FWD_SUB = 2;
    localparam int CTRL_OOS_LO = 3;
    localparam int CTRL_OOS_HI = 4;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] IDLE_RST = 8'h7C;
    localparam logic [7:0] MASK_RST = 8'h00;

    // Interrupt status bit positions
    localparam int EV_MAIN_RED = 0;
    localparam int EV_MAIN_SYNC = 1;
    localparam int EV_OOS_ON = 2;
    localparam int EV_OOS_OFF = 3;
    localparam int EV_W = 4;

    // Out-of-service signaling modes
    typedef enum logic [1:0] {
        OOS_MARK,
        OOS_SPACE,
        OOS_MARK_SPACE,
        OOS_SPACE_MARK
    } oos_mode_t;

    // Alarm inputs of both links
    typedef struct packed {
        logic main_red;
        logic main_yellow;
        logic sub_red;
        logic sub_yellow;
        logic sub_oos;
    } alarm_in_t;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// File: logic/cycle_timer.sv
// Restartable down-counter that flags when a loaded span has elapsed.
// Assumes the span fits the counter width.
module cycle_timer #(
    parameter int W = 27
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [W-1:0] span,
    input wire logic run,
    output logic done
);
    logic [W-1:0] cnt_ff;
    logic done_ff;
    wire logic at_end = (cnt_ff <= {{(W-1){1'b0}}, 1'b1});

    // Load on start, count while run, stop at end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            done_ff <= 1'b0;
        end else if (start) begin
            cnt_ff <= span;
            done_ff <= 1'b0;
        end else if (!run) begin
            done_ff <= 1'b0;
        end else if (!done_ff) begin
            cnt_ff <= at_end ? '0 : cnt_ff - 1'b1;
            done_ff <= at_end;
        end
    end

    assign done = done_ff;
endmodule

// File: logic/alarm_oos_top.sv
// Alarm recovery, idle fill, yellow forwarding and out-of-service override.
// Assumes alarm and slot inputs come from framers on other clocks.
module alarm_oos_top #(
    parameter int SYNC_FAST = alarm_oos_pkg::SYNC_FAST_CYC,
    parameter int SYNC_STD = alarm_oos_pkg::SYNC_STD_CYC,
    parameter int OOS_SPAN = alarm_oos_pkg::OOS_CYC,
    parameter int TW = 27
) (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic IRQ,
    input wire logic MAIN_RED,
    input wire logic MAIN_YELLOW,
    input wire logic SUB_RED,
    input wire logic SUB_YELLOW,
    input wire logic SUB_OOS,
    input wire logic SLOT_ASSIGNED,
    input wire logic [7:0] SLOT_DATA,
    input wire logic [3:0] SUB_ABCD,
    output logic [7:0] MAIN_TX_DATA,
    output logic [7:0] SUB_TX_DATA,
    output logic [3:0] MAIN_ABCD,
    output logic MAIN_SEND_YELLOW,
    output logic SUB_SEND_YELLOW,
    output logic MAIN_IN_SYNC
);
    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    localparam int NS = 18;
    logic [NS-1:0] s1_ff;
    logic [NS-1:0] s2_ff;
    wire logic [9:0] raw = {MAIN_RED, MAIN_YELLOW, SUB_RED, SUB_YELLOW, SUB_OOS,
                            SLOT_ASSIGNED, SUB_ABCD};
    wire logic [NS-1:0] raw_all = {raw, SLOT_DATA};

    // Two-stage sync of all link-side inputs
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s1_ff <= '0;
            s2_ff <= '0;
        end else begin
            s1_ff <= raw_all;
            s2_ff <= s1_ff;
        end
    end

    alarm_oos_pkg::alarm_in_t al;
    assign al = s2_ff[17:13];
    wire logic slot_asg = s2_ff[12];
    wire logic [3:0] sub_abcd = s2_ff[11:8];
    wire logic [7:0] slot_data = s2_ff[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Register file
    alarm_oos_pkg::reg_req_t req;
    assign req = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

    logic [7:0] ctrl_ff;
    logic [7:0] idle_ff;
    logic [alarm_oos_pkg::EV_W-1:0] ist_ff;
    logic [alarm_oos_pkg::EV_W-1:0] imask_ff;
    logic [7:0] rdata_ff;
    logic irq_ff;

    wire logic hit_ctrl = req.addr == alarm_oos_pkg::OFS_CTRL;
    wire logic hit_idle = req.addr == alarm_oos_pkg::OFS_IDLE;
    wire logic hit_stat = req.addr == alarm_oos_pkg::OFS_STAT;
    wire logic hit_ist = req.addr == alarm_oos_pkg::OFS_IRQ_STAT;
    wire logic hit_imask = req.addr == alarm_oos_pkg::OFS_IRQ_MASK;

    wire logic sync_std = ctrl_ff[alarm_oos_pkg::CTRL_SYNC_STD];
    wire logic fwd_main = ctrl_ff[alarm_oos_pkg::CTRL_FWD_MAIN];
    wire logic fwd_sub = ctrl_ff[alarm_oos_pkg::CTRL_FWD_SUB];
    alarm_oos_pkg::oos_mode_t oos_mode;
    assign oos_mode = alarm_oos_pkg::oos_mode_t'(
        ctrl_ff[alarm_oos_pkg::CTRL_OOS_HI:alarm_oos_pkg::CTRL_OOS_LO]);

    // Control and idle byte writes
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_ff <= alarm_oos_pkg::CTRL_RST;
            idle_ff <= alarm_oos_pkg::IDLE_RST;
            imask_ff <= alarm_oos_pkg::MASK_RST[alarm_oos_pkg::EV_W-1:0];
        end else if (req.wr) begin
            if (hit_ctrl) ctrl_ff <= {3'b000, req.wdata[4:0]};
            if (hit_idle) idle_ff <= req.wdata;
            if (hit_imask) imask_ff <= req.wdata[alarm_oos_pkg::EV_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Red alarm recovery
    logic red_d_ff;
    logic in_sync_ff;
    logic sync_done;
    wire logic red_fall = red_d_ff && !al.main_red;
    wire logic [TW-1:0] sync_span = sync_std ? TW'(SYNC_STD) : TW'(SYNC_FAST);

    cycle_timer #(.W(TW)) u_sync_timer (
        .clk(MCLK),
        .rst_n(RESET_N),
        .start(red_fall),
        .span(sync_span),
        .run(!al.main_red && !in_sync_ff),
        .done(sync_done)
    );

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            red_d_ff <= 1'b0;
            in_sync_ff <= 1'b1;
        end else begin
            red_d_ff <= al.main_red;
            if (al.main_red) in_sync_ff <= 1'b0;
            else if (sync_done) in_sync_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Out-of-service override
    logic oos_d_ff;
    logic oos_done;
    wire logic oos_rise = al.sub_oos && !oos_d_ff;
    wire logic oos_fall = !al.sub_oos && oos_d_ff;

    cycle_timer #(.W(TW)) u_oos_timer (
        .clk(MCLK),
        .rst_n(RESET_N),
        .start(oos_rise),
        .span(TW'(OOS_SPAN)),
        .run(al.sub_oos),
        .done(oos_done)
    );

    wire logic ab_level = (oos_mode == alarm_oos_pkg::OOS_MARK) ? 1'b1 :
                          (oos_mode == alarm_oos_pkg::OOS_SPACE) ? 1'b0 :
                          (oos_mode == alarm_oos_pkg::OOS_MARK_SPACE) ? !oos_done :
                          oos_done;
    wire logic [3:0] nxt_abcd = al.sub_oos ? {ab_level, ab_level, sub_abcd[1:0]} : sub_abcd;

    ////////////////////////////////////////////////////////////////////////
    // Data path and alarm forwarding
    // idle byte on unassigned slots
    wire logic [7:0] nxt_main_tx = slot_asg ? slot_data : idle_ff;
    wire logic [7:0] nxt_sub_tx = al.main_red ? 8'hFF : (slot_asg ? slot_data : idle_ff);
    wire logic nxt_sub_yel = fwd_main && al.main_yellow;
    // sublink yellow or red to main
    wire logic nxt_main_yel = fwd_sub && (al.sub_yellow || al.sub_red);

    logic [7:0] main_tx_ff;
    logic [7:0] sub_tx_ff;
    logic [3:0] abcd_ff;
    logic main_yel_ff;
    logic sub_yel_ff;

    // Output registers
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            main_tx_ff <= alarm_oos_pkg::IDLE_RST;
            sub_tx_ff <= alarm_oos_pkg::IDLE_RST;
            abcd_ff <= 4'h0;
            main_yel_ff <= 1'b0;
            sub_yel_ff <= 1'b0;
            oos_d_ff <= 1'b0;
        end else begin
            main_tx_ff <= nxt_main_tx;
            sub_tx_ff <= nxt_sub_tx;
            abcd_ff <= nxt_abcd;
            main_yel_ff <= nxt_main_yel;
            sub_yel_ff <= nxt_sub_yel;
            oos_d_ff <= al.sub_oos;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, set wins over clear
    wire logic [alarm_oos_pkg::EV_W-1:0] ev = {oos_fall, oos_rise,
                                               sync_done && !in_sync_ff, red_fall ? 1'b0 :
                                               (al.main_red && !red_d_ff)};
    wire logic [alarm_oos_pkg::EV_W-1:0] w1c = (req.wr && hit_ist) ?
                                               req.wdata[alarm_oos_pkg::EV_W-1:0] : '0;
    wire logic [alarm_oos_pkg::EV_W-1:0] nxt_ist = (ist_ff & ~w1c) | ev;

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ist_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            ist_ff <= nxt_ist;
            irq_ff <= |(nxt_ist & imask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path
    wire logic [7:0] stat_word = {2'b00, in_sync_ff, al.sub_oos, al.sub_yellow, al.sub_red,
                                  al.main_yellow, al.main_red};
    wire logic [7:0] rd_mux = hit_ctrl ? ctrl_ff :
                              hit_idle ? idle_ff :
                              hit_stat ? stat_word :
                              hit_ist ? {4'h0, ist_ff} :
                              hit_imask ? {4'h0, imask_ff} : 8'h00;

    // Read data one cycle after strobe
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) rdata_ff <= 8'h00;
        else rdata_ff <= req.rd ? rd_mux : 8'h00;
    end

    assign RDATA = rdata_ff;
    assign IRQ = irq_ff;
    assign MAIN_TX_DATA = main_tx_ff;
    assign SUB_TX_DATA = sub_tx_ff;
    assign MAIN_ABCD = abcd_ff;
    assign MAIN_SEND_YELLOW = main_yel_ff;
    assign SUB_SEND_YELLOW = sub_yel_ff;
    assign MAIN_IN_SYNC = in_sync_ff;
endmodule

// File: sim/t1_far_end.sv
// Far-end framer view of main link and sublink.
// Assumes the bench commands alarms, slot map and signaling.
module t1_far_end (
    input wire logic clk,
    input wire logic rst_n,
    input wire alarm_oos_pkg::alarm_in_t alm_cmd,
    input wire logic [23:0] map_cmd,
    input wire logic [3:0] abcd_cmd,
    output alarm_oos_pkg::alarm_in_t alm,
    output logic slot_used,
    output logic [7:0] slot_data,
    output logic [3:0] abcd
);
    logic [4:0] slot_ff;
    // Slot rotation, payload differs every slot
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_ff <= 5'h0;
            alm <= '0;
            slot_used <= 1'b0;
            slot_data <= 8'h00;
            abcd <= 4'h0;
        end else begin
            slot_ff <= (slot_ff == 5'h17) ? 5'h0 : slot_ff + 5'h1;
            alm <= alm_cmd;
            slot_used <= map_cmd[slot_ff];
            slot_data <= {slot_ff, 3'h3};
            abcd <= abcd_cmd;
        end
    end
endmodule

// File: sim/alarm_oos_monitor.sv
// Port checker for the alarm and out-of-service block.
// Assumes three cycles from input pins to registered outputs.
module alarm_oos_monitor (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic WR,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic MAIN_RED,
    input wire logic MAIN_YELLOW,
    input wire logic SUB_RED,
    input wire logic SUB_YELLOW,
    input wire logic SUB_OOS,
    input wire logic SLOT_ASSIGNED,
    input wire logic [7:0] SLOT_DATA,
    input wire logic [7:0] MAIN_TX_DATA,
    input wire logic [7:0] SUB_TX_DATA,
    input wire logic [3:0] SUB_ABCD,
    input wire logic [3:0] MAIN_ABCD,
    input wire logic MAIN_SEND_YELLOW,
    input wire logic SUB_SEND_YELLOW,
    input wire logic MAIN_IN_SYNC
);
    logic [2:0] up_ff;
    logic [1:0] mode_ff;
    logic ok;
    // Cycles since reset, signaling mode shadow
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            up_ff <= 3'h0;
            mode_ff <= 2'h0;
        end else begin
            if (up_ff != 3'h5) up_ff <= up_ff + 3'h1;
            if (WR && ADDR == alarm_oos_pkg::OFS_CTRL) mode_ff <= WDATA[4:3];
        end
    end
    assign ok = up_ff == 3'h5;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    ////////////////////////////////////////////////////////////////////////////
    a_slot_pass: assert property (ok && $past(SLOT_ASSIGNED, 3) |->
        MAIN_TX_DATA == $past(SLOT_DATA, 3)) else $error("slot data not passed");
    a_red_ones: assert property (ok && $past(MAIN_RED, 3) |-> SUB_TX_DATA == 8'hFF)
        else $error("sublink not all ones");
    a_sync_drop: assert property (ok && $past(MAIN_RED, 3) |-> !MAIN_IN_SYNC)
        else $error("in sync during red");
    a_fwd_main: assert property (ok && SUB_SEND_YELLOW |-> $past(MAIN_YELLOW, 3))
        else $error("sublink yellow without cause");
    a_fwd_sub: assert property (ok && MAIN_SEND_YELLOW |->
        $past(SUB_YELLOW | SUB_RED, 3)) else $error("main yellow without cause");
    a_cd_pass: assert property (ok |-> MAIN_ABCD[1:0] == $past(SUB_ABCD[1:0], 3))
        else $error("C D bits altered");
    a_ab_pass: assert property (ok && !$past(SUB_OOS, 3) && !$past(SUB_OOS, 4) |->
        MAIN_ABCD[3:2] == $past(SUB_ABCD[3:2], 3)) else $error("A B not passed");
    a_oos_fixed: assert property (ok && $past(SUB_OOS, 3) && !mode_ff[1] &&
        $past(mode_ff, 4) == mode_ff |-> MAIN_ABCD[3:2] == {2{mode_ff == 2'h0}})
        else $error("fixed mode A B wrong");
endmodule
bind alarm_oos_top alarm_oos_monitor alarm_oos_monitor_inst (.*);

// File: sim/tb_alarm_oos_top.sv
// Self-checking bench for the alarm and out-of-service block.
// Assumes short spans set by parameter and a far-end model.
module tb_alarm_oos_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SF = 20;
    localparam int SS = 50;
    localparam int OS = 30;
    logic mclk, reset_n, wr, rd, irq, used, sub_yel, main_yel, in_sync;
    logic [3:0] addr, abcd_cmd, abcd, main_abcd;
    logic [7:0] wdata, rdata, slot_data, main_tx, sub_tx;
    logic [23:0] map_cmd;
    alarm_oos_pkg::alarm_in_t alm_cmd, alm;
    int bad_count = 0;
    int tests_run = 0;
    alarm_oos_top #(.SYNC_FAST(SF), .SYNC_STD(SS), .OOS_SPAN(OS)) alarm_oos_top_inst (
        .MCLK(mclk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .IRQ(irq), .MAIN_RED(alm.main_red), .MAIN_YELLOW(alm.main_yellow),
        .SUB_RED(alm.sub_red), .SUB_YELLOW(alm.sub_yellow), .SUB_OOS(alm.sub_oos),
        .SLOT_ASSIGNED(used), .SLOT_DATA(slot_data), .SUB_ABCD(abcd), .MAIN_TX_DATA(main_tx),
        .SUB_TX_DATA(sub_tx), .MAIN_ABCD(main_abcd), .MAIN_SEND_YELLOW(main_yel),
        .SUB_SEND_YELLOW(sub_yel), .MAIN_IN_SYNC(in_sync));
    t1_far_end t1_far_end_inst (.clk(mclk), .rst_n(reset_n), .alm_cmd(alm_cmd),
        .map_cmd(map_cmd), .abcd_cmd(abcd_cmd), .alm(alm), .slot_used(used),
        .slot_data(slot_data), .abcd(abcd));
    ////////////////////////////////////////////////////////////////////////////
    // Shared bus and compare tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wrr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        {rd, addr} <= {1'b1, a};
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic look(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Reset values, unmapped place, idle byte
    task automatic t_regs();
        logic [7:0] v[3] = '{8'h00, 8'hFF, 8'h5A};
        rdc(alarm_oos_pkg::OFS_CTRL, alarm_oos_pkg::CTRL_RST);
        rdc(alarm_oos_pkg::OFS_IDLE, alarm_oos_pkg::IDLE_RST);
        rdc(alarm_oos_pkg::OFS_IRQ_MASK, alarm_oos_pkg::MASK_RST);
        wrr(4'hF, 8'h55);
        rdc(4'hF, 8'h00);
        foreach (v[i]) begin
            wrr(alarm_oos_pkg::OFS_IDLE, v[i]);
            look(6);
            chk(main_tx, v[i]);
        end
        map_cmd <= 24'hA5_A5A5;
    endtask
    // Red alarm, all ones, recovery delay, interrupt
    task automatic t_red();
        int n;
        for (int s = 0; s < 2; s++) begin
            wrr(alarm_oos_pkg::OFS_CTRL, 8'(s));
            wrr(alarm_oos_pkg::OFS_IRQ_MASK, 8'h01);
            alm_cmd.main_red <= 1'b1;
            look(6);
            chk(sub_tx, 8'hFF);
            chk({7'h0, in_sync}, 8'h00);
            rdc(alarm_oos_pkg::OFS_STAT, 8'h01);
            chk({7'h0, irq}, 8'h01);
            wrr(alarm_oos_pkg::OFS_IRQ_STAT, 8'h01);
            look(2);
            chk({7'h0, irq}, 8'h00);
            @(posedge mclk);
            alm_cmd.main_red <= 1'b0;
            n = 0;
            while (in_sync !== 1'b1 && n < 300) begin
                @(negedge mclk);
                n++;
            end
            chk(8'(n >= (s ? SS : SF) && n <= (s ? SS : SF) + 8), 8'h01);
            rdc(alarm_oos_pkg::OFS_IRQ_STAT, 8'h02);
            wrr(alarm_oos_pkg::OFS_IRQ_STAT, 8'h0F);
        end
    endtask
    // Yellow forwarding in both directions
    task automatic t_yellow();
        logic [4:0] c;
        for (int i = 0; i < 32; i++) begin
            c = 5'(i);
            wrr(alarm_oos_pkg::OFS_CTRL, {5'h0, c[1:0], 1'b0});
            alm_cmd.main_yellow <= c[2];
            alm_cmd.sub_yellow <= c[3] & ~c[4];
            alm_cmd.sub_red <= c[3] & c[4];
            look(5);
            chk({7'h0, sub_yel}, {7'h0, c[0] & c[2]});
            chk({7'h0, main_yel}, {7'h0, c[1] & c[3]});
        end
    endtask
    // Out-of-service modes, then timer restart
    task automatic t_oos();
        logic [1:0] ab0, ab1;
        for (int m = 0; m < 4; m++) begin
            ab0 = (m == 0 || m == 2) ? 2'b11 : 2'b00;
            ab1 = (m == 0 || m == 3) ? 2'b11 : 2'b00;
            wrr(alarm_oos_pkg::OFS_CTRL, 8'(m << 3));
            alm_cmd.sub_oos <= 1'b1;
            look(8);
            chk({4'h0, main_abcd}, {4'h0, ab0, 2'b10});
            look(OS);
            chk({4'h0, main_abcd}, {4'h0, ab1, 2'b10});
            @(posedge mclk);
            alm_cmd.sub_oos <= ~alm_cmd.sub_oos;
            look(6);
            chk({4'h0, main_abcd}, 8'h06);
        end
        rdc(alarm_oos_pkg::OFS_IRQ_STAT, 8'h0C);
        wrr(alarm_oos_pkg::OFS_CTRL, 8'h10);
        for (int k = 0; k < 2; k++) begin
            alm_cmd.sub_oos <= 1'b1;
            look(20);
            @(posedge mclk);
            alm_cmd.sub_oos <= k[0];
            look(4);
            @(posedge mclk);
        end
        // First span would have ended; second entry still in its mark phase
        look(2);
        chk({6'h0, main_abcd[3:2]}, 8'h03);
        look(8);
        chk({6'h0, main_abcd[3:2]}, 8'h00);
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        #(100 * 6000);
        bad_count++;
        end_of_test();
    end
    initial begin
        {reset_n, wr, rd, addr, wdata, map_cmd} = '0;
        alm_cmd = '0;
        abcd_cmd = 4'h6;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        t_regs();
        t_red();
        t_yellow();
        t_oos();
        end_of_test();
    end
endmodule
